// *** design/compare_control_defines.vh ***
`ifndef COMPARE_CONTROL_DEFINES_VH
`define COMPARE_CONTROL_DEFINES_VH
// register byte addresses on the apb
`define ADDR_CTRL_ONE        12'h000
`define ADDR_IRQ_STATUS      12'h004
`define ADDR_IRQ_MASK        12'h008
// control register fields
`define BIT_HALT_IN_IDLE     13
`define POS_TIME_BASE_HI     12
`define POS_TIME_BASE_LO     10
`define BIT_FAULT_B_ENABLE   8
`define BIT_FAULT_A_ENABLE   7
`define BIT_FAULT_B_FLAG     5
`define BIT_FAULT_A_FLAG     4
`define BIT_TRIGGER_BEHAV    3
`define POS_COMPARE_MODE_HI  2
`define POS_COMPARE_MODE_LO  0
// writable bits of the control register
`define CTRL_WRITE_MASK      16'h3D8F
`define CTRL_RESET           16'h0000
// time base codes
`define TB_PERIPH_CLK        3'h7
`define TB_RESERVED          3'h6
`define TB_TRIG_GEN          3'h5
`define TB_TIMER_0           3'h0
`define TB_TIMER_1           3'h1
`define TB_TIMER_2           3'h2
// interrupt status/mask bits
`define IRQ_FAULT_A          0
`define IRQ_FAULT_B          1
`define IRQ_RESET            2'h0
`endif

// *** design/output_compare_control_one.v ***
// Behaviour
// - time base: 111 periph, 110 reserved, 101 trigger
// - fault b enable gates fault b input
// - fault a enable gates fault a pin
// - fault flags set by hardware on faults
// - channels one-four drive trigger outputs four-seven
`timescale 1ns/1ps
`default_nettype none
`include "compare_control_defines.vh"
module output_compare_control_one #(
  parameter CHANNELS = 4
) (
  input  wire                i_clk_sys,
  input  wire                i_resetn,
  input  wire                i_psel,
  input  wire                i_penable,
  input  wire                i_pwrite,
  input  wire [11:0]         i_paddr,
  input  wire [31:0]         i_pwdata,
  output wire                o_pready,
  output reg  [31:0]         o_prdata,
  output wire                o_pslverr,
  input  wire                i_fault_a_pin,
  input  wire                i_fault_b,
  input  wire                i_cpu_idle,
  input  wire                i_periph_tick,
  input  wire                i_trig_gen_tick,
  input  wire [2:0]          i_timer_tick,
  input  wire [CHANNELS-1:0] i_channel_event,
  output reg                 o_time_base_tick,
  output wire                o_channel_run,
  output wire                o_fault_active,
  output reg  [CHANNELS-1:0] o_trigger_generator_output,
  output wire                o_irq
);
  // fault inputs: index 0 is fault a, index 1 is fault b
  localparam FAULTS = 2;
  localparam [15:0] CTRL_RESET_VALUE = `CTRL_RESET;

  // control register fields, one register per field
  reg                 halt_in_idle;
  reg  [2:0]          time_base_select;
  reg                 fault_b_enable;
  reg                 fault_a_enable;
  reg                 fault_b_flag;
  reg                 fault_a_flag;
  reg                 trigger_behaviour;
  reg  [2:0]          compare_mode_field;
  // interrupt status and mask
  reg  [1:0]          irq_status;
  reg  [1:0]          irq_mask;
  // combinational next values
  reg                 next_tick;
  reg  [31:0]         next_rdata;
  wire [CHANNELS-1:0] next_trigger;
  // register view and write data
  wire [15:0]         ctrl;
  wire [15:0]         ctrl_wdata;
  // fault paths, one bit per fault input
  wire [FAULTS-1:0]   fault_pins;
  wire [FAULTS-1:0]   fault_enables;
  wire [FAULTS-1:0]   fault_flags;
  wire [FAULTS-1:0]   fault_seen;
  wire [FAULTS-1:0]   fault_rise;
  // bus decode
  wire                setup_phase;
  wire                wr_en;
  wire                rd_en;
  wire                wr_ctrl;
  wire                wr_mask;
  wire                rd_status;
  genvar              g;

  // apb strobes; every access completes with no wait state
  assign setup_phase = i_psel & ~i_penable;
  assign wr_en       = i_psel & i_penable & i_pwrite;
  assign rd_en       = i_psel & i_penable & ~i_pwrite;
  assign wr_ctrl     = wr_en & (i_paddr == `ADDR_CTRL_ONE);
  assign wr_mask     = wr_en & (i_paddr == `ADDR_IRQ_MASK);
  assign rd_status   = rd_en & (i_paddr == `ADDR_IRQ_STATUS);
  assign o_pready    = 1'b1;
  assign o_pslverr   = 1'b0;

  // fault inputs gathered into vectors in index order
  assign fault_pins[`IRQ_FAULT_A]    = i_fault_a_pin;
  assign fault_pins[`IRQ_FAULT_B]    = i_fault_b;
  assign fault_enables[`IRQ_FAULT_A] = fault_a_enable;
  assign fault_enables[`IRQ_FAULT_B] = fault_b_enable;
  assign fault_flags[`IRQ_FAULT_A]   = fault_a_flag;
  assign fault_flags[`IRQ_FAULT_B]   = fault_b_flag;

  // per fault input: three stage synchroniser, a level change is taken once
  // stages two and three agree, then the enable decides whether it counts
  generate
    for (g = 0; g < FAULTS; g = g + 1) begin : fault_cond
      reg [2:0] sync;
      reg       level;
      always @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
          sync  <= 3'h0;
          level <= 1'b0;
        end else begin
          sync <= {sync[1:0], fault_pins[g]};
          if (sync[2] == sync[1])
            level <= sync[2];
        end
      end
      assign fault_seen[g] = level & fault_enables[g]; // a disabled input is ignored
      assign fault_rise[g] = fault_seen[g] & ~fault_flags[g];
    end
  endgenerate
  assign o_fault_active = |fault_flags;

  // only the writable bits of a control write reach the fields
  assign ctrl_wdata = i_pwdata[15:0] & `CTRL_WRITE_MASK;

  // software fields of the control register
  always @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      halt_in_idle       <= CTRL_RESET_VALUE[`BIT_HALT_IN_IDLE];
      time_base_select   <= CTRL_RESET_VALUE[`POS_TIME_BASE_HI:`POS_TIME_BASE_LO];
      fault_b_enable     <= CTRL_RESET_VALUE[`BIT_FAULT_B_ENABLE];
      fault_a_enable     <= CTRL_RESET_VALUE[`BIT_FAULT_A_ENABLE];
      trigger_behaviour  <= CTRL_RESET_VALUE[`BIT_TRIGGER_BEHAV];
      compare_mode_field <= CTRL_RESET_VALUE[`POS_COMPARE_MODE_HI:`POS_COMPARE_MODE_LO];
    end else if (wr_ctrl) begin
      halt_in_idle       <= ctrl_wdata[`BIT_HALT_IN_IDLE];
      time_base_select   <= ctrl_wdata[`POS_TIME_BASE_HI:`POS_TIME_BASE_LO];
      fault_b_enable     <= ctrl_wdata[`BIT_FAULT_B_ENABLE];
      fault_a_enable     <= ctrl_wdata[`BIT_FAULT_A_ENABLE];
      trigger_behaviour  <= ctrl_wdata[`BIT_TRIGGER_BEHAV];
      compare_mode_field <= ctrl_wdata[`POS_COMPARE_MODE_HI:`POS_COMPARE_MODE_LO];
    end
  end

  // condition flags follow the enabled fault level; software cannot write them
  always @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      fault_b_flag <= CTRL_RESET_VALUE[`BIT_FAULT_B_FLAG];
      fault_a_flag <= CTRL_RESET_VALUE[`BIT_FAULT_A_FLAG];
    end else begin
      fault_b_flag <= fault_seen[`IRQ_FAULT_B];
      fault_a_flag <= fault_seen[`IRQ_FAULT_A];
    end
  end

  // register view: unimplemented bits read as zero
  assign ctrl = {2'h0, halt_in_idle, time_base_select, 1'b0,
                 fault_b_enable, fault_a_enable, 1'b0,
                 fault_b_flag, fault_a_flag,
                 trigger_behaviour, compare_mode_field};

  // interrupt mask register
  always @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn)
      irq_mask <= `IRQ_RESET;
    else if (wr_mask)
      irq_mask <= i_pwdata[1:0];
  end

  // sticky interrupt status; a read clears only the bits it returned, so an
  // event that lands between capture and clear is kept, and a set always wins
  always @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn)
      irq_status <= `IRQ_RESET;
    else if (rd_status)
      irq_status <= (irq_status & ~o_prdata[1:0]) | fault_rise;
    else
      irq_status <= irq_status | fault_rise;
  end
  assign o_irq = |(irq_status & irq_mask);

  // read data mux, unmapped addresses read as zero
  always @* begin
    next_rdata = 32'h0000_0000;
    case (i_paddr)
      `ADDR_CTRL_ONE:   next_rdata = {16'h0000, ctrl};
      `ADDR_IRQ_STATUS: next_rdata = {30'h0000_0000, irq_status};
      `ADDR_IRQ_MASK:   next_rdata = {30'h0000_0000, irq_mask};
      default:          next_rdata = 32'h0000_0000;
    endcase
  end

  // the channel halts only when halt in idle is set and the processor idles
  assign o_channel_run = ~(halt_in_idle & i_cpu_idle);

  // time base source; reserved and unassigned codes give no tick
  always @* begin
    next_tick = 1'b0;
    case (time_base_select)
      `TB_PERIPH_CLK: next_tick = i_periph_tick;
      `TB_RESERVED:   next_tick = 1'b0;
      `TB_TRIG_GEN:   next_tick = i_trig_gen_tick;
      `TB_TIMER_0:    next_tick = i_timer_tick[0];
      `TB_TIMER_1:    next_tick = i_timer_tick[1];
      `TB_TIMER_2:    next_tick = i_timer_tick[2];
      default:        next_tick = 1'b0;
    endcase
  end

  // compare channel n drives trigger generator output n plus three, so
  // index 0 is trigger output four and index 3 is trigger output seven
  generate
    for (g = 0; g < CHANNELS; g = g + 1) begin : trig_map
      assign next_trigger[g] = i_channel_event[g];
    end
  endgenerate

  // read data is captured in the setup cycle and stands through the access
  always @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn)
      o_prdata <= 32'h0000_0000;
    else if (setup_phase)
      o_prdata <= next_rdata;
  end

  // registered tick, gated by the run state so a halted channel sees none
  always @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn)
      o_time_base_tick <= 1'b0;
    else
      o_time_base_tick <= next_tick & o_channel_run;
  end

  // trigger generator outputs, one cycle behind the compare events
  always @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn)
      o_trigger_generator_output <= {CHANNELS{1'b0}};
    else
      o_trigger_generator_output <= next_trigger;
  end
endmodule // output_compare_control_one
`default_nettype wire

// *** tb/fault_partner.sv ***
`timescale 1ns/1ps
`default_nettype none
module fault_partner (
  input  wire logic       clk,
  input  wire logic [1:0] want,
  output var  logic       fa,
  output var  logic       fb,
  output var  logic [3:0] ev
);
  // fault levels follow the bench, compare events are random
  always @(posedge clk) begin
    fa <= want[0];
    fb <= want[1];
    ev <= 4'($urandom);
  end
endmodule // fault_partner
`default_nettype wire

// *** tb/occ_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module occ_props #(parameter CHANNELS = 4) (
  input wire logic i_clk_sys, i_resetn, i_cpu_idle, i_fault_a_pin, i_fault_b,
  input wire logic i_periph_tick, i_trig_gen_tick, o_pready, o_pslverr,
  input wire logic o_channel_run, o_fault_active, o_time_base_tick,
  input wire logic [2:0] i_timer_tick,
  input wire logic [CHANNELS-1:0] i_channel_event, o_trigger_generator_output
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);
  chk_apb_answer: assert property (o_pready && !o_pslverr) else $error("bad apb answer");
  chk_trig_map: assert property (
    $past(i_resetn) |-> o_trigger_generator_output == $past(i_channel_event))
    else $error("trigger output wrong");
  chk_run_awake: assert property (!i_cpu_idle |-> o_channel_run)
    else $error("channel halted while awake");
  chk_halt_tick: assert property (!o_channel_run |=> !o_time_base_tick)
    else $error("tick while halted");
  chk_tick_cause: assert property (
    $past(i_resetn) && o_time_base_tick |-> $past(i_periph_tick | i_trig_gen_tick | (|i_timer_tick)))
    else $error("tick without source");
  chk_fault_quiet: assert property (
    (!i_fault_a_pin && !i_fault_b) [*6] |=> !o_fault_active) else $error("fault without input");
endmodule // occ_props
bind output_compare_control_one occ_props #(.CHANNELS(CHANNELS)) i_props (.*);
`default_nettype wire

// *** tb/test_output_compare_control_one.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_output_compare_control_one;
  logic clk = 0, rstn = 0, psel = 0, pen = 0, pwr = 0, idle = 0, pt = 0, tt = 0;
  logic [2:0] tmr = 0; logic [11:0] addr = 0; logic [31:0] wd = 0, rd; logic [1:0] want = 0;
  logic rdy, slv, tbt, run, fact, fa, fb, irq; logic [3:0] ev, trg;
  int failures = 0, n_compared = 0, cyc = 0; logic [31:0] q[$]; logic [15:0] v;
  logic [2:0] sel = 0; logic etk = 0, ctk = 0;
  always #2 clk = ~clk;
  fault_partner i_fault_partner (.clk(clk), .want(want), .fa(fa), .fb(fb), .ev(ev));
  output_compare_control_one i_output_compare_control_one (.i_clk_sys(clk), .i_resetn(rstn),
    .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(addr), .i_pwdata(wd),
    .o_pready(rdy), .o_prdata(rd), .o_pslverr(slv), .i_fault_a_pin(fa), .i_fault_b(fb),
    .i_cpu_idle(idle), .i_periph_tick(pt), .i_trig_gen_tick(tt), .i_timer_tick(tmr),
    .i_channel_event(ev), .o_time_base_tick(tbt), .o_channel_run(run),
    .o_fault_active(fact), .o_trigger_generator_output(trg), .o_irq(irq));
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin failures++; $display("[FAIL] %0t %h %h", $time, g, e); end
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk); psel <= 1; pwr <= w; addr <= a; wd <= d;
    @(posedge clk); pen <= 1;
    do @(posedge clk); while (!rdy);
    psel <= 0; pen <= 0;
  endtask
  task automatic rdx(input logic [11:0] a, input logic [31:0] e);
    q.push_back(e); bus(0, a, 0);
  endtask
  task stop_test;
    if (failures == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // random ticks, read data checker and timeout
  always @(posedge clk) {pt, tt, tmr} <= 5'($urandom);
  always @(posedge clk) if (psel && pen && rdy && !pwr) cmp(rd, q.pop_front());
  always @(posedge clk) if (++cyc > 3000) begin failures++; stop_test; end
  // expected time base tick: the selected source, one cycle later
  always @(posedge clk) begin
    if (ctk) cmp(32'(tbt), 32'(etk));
    etk <= (sel == 3'h7) ? pt : (sel == 3'h5) ? tt : (sel < 3'h3) ? tmr[sel] : 1'b0;
  end
  initial begin
    void'($urandom(32'hEBBC7E83));
    repeat (2) @(posedge clk); rstn <= 1;
    rdx(12'h000, 32'h0);
    bus(1, 12'h00C, $urandom); rdx(12'h00C, 32'h0);
    for (int i = 0; i < 4; i++) begin
      v = 16'($urandom); v[12:10] = 3'(7 - i);
      bus(1, 12'h000, 32'(v)); sel <= 3'(7 - i);
      rdx(12'h000, 32'(v & 16'h3D8F));
      ctk <= 1; repeat (8) @(posedge clk); ctk <= 0;
    end
    bus(1, 12'h000, 32'h0080); want <= 2'h3; repeat (8) @(posedge clk);
    rdx(12'h000, 32'h0090);
    @(negedge clk); cmp(32'(fact), 1);
    rdx(12'h004, 32'h1); rdx(12'h004, 32'h0);
    bus(1, 12'h000, 32'h0180); repeat (8) @(posedge clk);
    rdx(12'h000, 32'h01B0); @(negedge clk); cmp(32'(irq), 0);
    bus(1, 12'h008, 32'h2); @(negedge clk); cmp(32'(irq), 1);
    rdx(12'h004, 32'h2); @(negedge clk); cmp(32'(irq), 0);
    want <= 2'h0; repeat (8) @(posedge clk); rdx(12'h000, 32'h0180);
    @(negedge clk); cmp(32'(fact), 0);
    idle <= 1; bus(1, 12'h000, 32'h2000); @(negedge clk); cmp(32'(run), 0);
    bus(1, 12'h000, 32'h0); @(negedge clk); cmp(32'(run), 1);
    stop_test;
  end
endmodule // test_output_compare_control_one
`default_nettype wire
